// File: core/erl_consts.svh
`ifndef ERL_CONSTS_SVH
`define ERL_CONSTS_SVH
`define ERL_OFF_BSTAT 8'h00
`define ERL_OFF_CTL   8'h04
`define ERL_OFF_BADDR 8'h08
`define ERL_OFF_FADDR 8'h0c
`define ERL_OFF_FSYN  8'h10
`define ERL_OFF_BTAG  8'h14
`define ERL_OFF_DSTAT 8'h18
`define ERL_OFF_DADDR 8'h1c
`define ERL_OFF_TSTAT 8'h20
`define ERL_OFF_TADDR 8'h24
`define ERL_OFF_IUCS  8'h28
`define ERL_OFF_VADDR 8'h2c
`define ERL_B_HARD    0
`define ERL_B_SOFT    1
`define ERL_B_TPERR   2
`define ERL_B_TCPERR  3
`define ERL_B_FECC    4
`define ERL_B_FDPERR  5
`define ERL_B_SECOND  6
`define ERL_B_FPRIM   7
`define ERL_B_HWRITE  8
`define ERL_C_EN      0
`define ERL_C_FLUSH   1
`define ERL_C_BUSY    2
`define ERL_I_EN      0
`define ERL_CTL_RST   1'b1
`define ERL_IUCS_RST  1'b1
`define ERL_K_HARD    2'h0
`define ERL_K_SOFT    2'h1
`define ERL_K_TPERR   2'h2
`define ERL_K_TCPERR  2'h3
`endif

// File: core/erl_pkg.sv
`default_nettype none
package erl_pkg;
  typedef enum logic [1:0]
  {
    NT_NONE = 2'h0,
    NT_SOFT = 2'h1,
    NT_HARD = 2'h3,
    NT_MCHK = 2'h2
  } erl_notify_t;
  typedef enum logic [2:0]
  {
    PS_IDLE = 3'h0,
    PS_PC   = 3'h1,
    PS_PSL  = 3'h3,
    PS_DET0 = 3'h2,
    PS_DET1 = 3'h6
  } erl_push_t;
endpackage
`default_nettype wire

// File: core/erl_w1c.sv
`timescale 1ns/1ps
`default_nettype none
module erl_w1c #(
  parameter int W = 1
) (
  input  wire logic         clk,     // system clock
  input  wire logic         rst_n,   // async reset, active low
  input  wire logic [W-1:0] set,     // hardware set pulses
  input  wire logic         clr_we,  // software write to this register
  input  wire logic [W-1:0] clr_msk, // ones clear the matching bits
  output logic      [W-1:0] q        // sticky flags
);
  generate
    if (W < 1)
    begin : g_chk
      $error("erl_w1c: W must be at least 1");
    end
  endgenerate

  // set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= (q & ~(clr_we ? clr_msk : '0)) | set;
  end
endmodule
`default_nettype wire

// File: core/erl_latch.sv
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "erl_consts.svh"
module erl_latch
  import erl_pkg::*;
#(
  parameter int TAGW = 16,
  parameter int SYNW = 8,
  parameter int NBLK = 1024,
  localparam int IDXW = $clog2(NBLK)
) (
  input  wire logic            clk,          // 50 MHz system clock
  input  wire logic            rst_n,        // async reset, active low
  input  wire logic [7:0]      addr,         // register byte address
  input  wire logic [31:0]     wr_data,      // register write data
  input  wire logic            wr_en,        // write strobe
  input  wire logic            rd_en,        // read strobe
  output logic      [31:0]     rd_data,      // read data, cycle after rd_en
  input  wire logic            bus_err_valid,// bus unit error pulse
  input  wire logic [1:0]      bus_err_kind, // hard, soft, tag, tag control
  input  wire logic            bus_err_write,// error came from a write
  input  wire logic [31:0]     bus_err_addr, // failing address
  input  wire logic [TAGW-1:0] bus_err_tag,  // tag read at the probe
  input  wire logic            fill_valid,   // quadword returned to cpu
  input  wire logic            fill_primary, // holds requested data
  input  wire logic            fill_ecc_err, // uncorrectable ecc
  input  wire logic            fill_par_err, // data parity error
  input  wire logic [31:0]     fill_addr,    // fill address
  input  wire logic [SYNW-1:0] fill_syn,     // ecc syndrome
  input  wire logic [TAGW-1:0] fill_tag,     // tag of filled block
  input  wire logic            dc_err_valid, // data cache error pulse
  input  wire logic [2:0]      dc_err_kind,  // tag, data, pte read (one-hot)
  input  wire logic [31:0]     dc_err_addr,  // data cache error address
  input  wire logic            tb_err_valid, // translation buffer parity
  input  wire logic [31:0]     tb_err_addr,  // translation buffer address
  input  wire logic            ic_err_valid, // instruction cache error
  input  wire logic [1:0]      ic_err_kind,  // tag, data (one-hot)
  input  wire logic [31:0]     ic_err_addr,  // instruction cache address
  input  wire logic            exc_take,     // cpu takes exception
  input  wire logic [31:0]     exc_pc,       // pc to push
  input  wire logic [31:0]     exc_psl,      // status word to push
  input  wire logic            flush_dirty,  // block at flush_idx is dirty
  output logic                 mchk_req,     // machine check pending
  output logic                 hard_irq,     // hard error interrupt
  output logic                 soft_irq,     // soft error interrupt
  output erl_notify_t          notify_top,   // highest pending notice
  output logic                 l1d_cache_en, // data cache enable
  output logic                 l2_cache_en,  // second-level cache enable
  output logic                 ic_en,        // instruction cache enable
  output logic                 push_valid,   // stack word valid
  output logic      [31:0]     push_data,    // stack word
  output logic                 flush_busy,   // flush walk running
  output logic      [IDXW-1:0] flush_idx,    // block being probed
  output logic                 wb_valid,     // victim writeback request
  output logic      [IDXW-1:0] wb_idx        // block to write back
);
  generate
    if (TAGW < 1 || TAGW > 32 || SYNW < 1 || SYNW > 32 || NBLK < 2)
    begin : g_chk
      $error("erl_latch: parameter out of range");
    end
  endgenerate

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [6:0]      bstat_q;
  logic [6:0]      bstat_set;
  logic [2:0]      dstat_q;
  logic [0:0]      tstat_q;
  logic [1:0]      vstat_q;
  logic            fprim_reg;
  logic            hwrite_reg;
  logic [31:0]     baddr_reg;
  logic [31:0]     faddr_reg;
  logic [SYNW-1:0] fsyn_reg;
  logic [TAGW-1:0] btag_reg;
  logic [31:0]     daddr_reg;
  logic [31:0]     taddr_reg;
  logic [31:0]     vaddr_reg;
  logic            ctl_en_reg;
  logic            iucs_en_reg;
  logic            mchk_reg;
  logic            bank_busy;
  logic            fill_err;
  logic            bus_cap;
  logic            fill_cap;
  logic            cache_err;
  logic            mchk_set;
  logic            ctl_we;
  logic [31:0]     rd_next;
  erl_push_t       ps_reg;
  logic            frame_mchk_reg;
  logic [31:0]     psl_hold_reg;
  logic [IDXW-1:0] idx_reg;

  // error classification
  assign fill_err  = fill_valid && (fill_ecc_err || fill_par_err);
  assign bank_busy = |bstat_q[`ERL_B_FDPERR:0];
  // first error owns address and status; later ones only flag
  assign bus_cap   = bus_err_valid && !bank_busy;
  assign fill_cap  = fill_err && !bank_busy && !bus_err_valid;
  assign cache_err = (bus_err_valid && bus_err_kind[1]) || fill_err
                     || dc_err_valid;
  // a primary-fill error checks even behind a latched write error
  assign mchk_set  = fill_err && fill_primary;
  assign ctl_we    = wr_en && hit(addr, `ERL_OFF_CTL);

  always_comb
  begin
    bstat_set = '0;
    if (bus_cap)
      bstat_set[bus_err_kind] = 1'b1;
    if (fill_cap)
    begin
      bstat_set[`ERL_B_FECC]   = fill_ecc_err;
      bstat_set[`ERL_B_FDPERR] = fill_par_err;
    end
    bstat_set[`ERL_B_SECOND] = (bank_busy && (bus_err_valid || fill_err))
                            || (bus_err_valid && fill_err);
  end

  erl_w1c #(.W(7)) u_bstat (
    .clk     (clk),
    .rst_n   (rst_n),
    .set     (bstat_set),
    .clr_we  (wr_en && hit(addr, `ERL_OFF_BSTAT)),
    .clr_msk (wr_data[6:0]),
    .q       (bstat_q)
  );

  erl_w1c #(.W(3)) u_dstat (
    .clk     (clk),
    .rst_n   (rst_n),
    .set     (dc_err_valid ? dc_err_kind : 3'h0),
    .clr_we  (wr_en && hit(addr, `ERL_OFF_DSTAT)),
    .clr_msk (wr_data[2:0]),
    .q       (dstat_q)
  );

  erl_w1c #(.W(1)) u_tstat (
    .clk     (clk),
    .rst_n   (rst_n),
    .set     (tb_err_valid),
    .clr_we  (wr_en && hit(addr, `ERL_OFF_TSTAT)),
    .clr_msk (wr_data[0:0]),
    .q       (tstat_q)
  );

  erl_w1c #(.W(2)) u_vstat (
    .clk     (clk),
    .rst_n   (rst_n),
    .set     (ic_err_valid ? ic_err_kind : 2'h0),
    .clr_we  (wr_en && hit(addr, `ERL_OFF_IUCS)),
    .clr_msk (wr_data[2:1]),
    .q       (vstat_q)
  );

  // captured error detail, written only by the owning first error
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baddr_reg  <= '0;
      fprim_reg  <= 1'b0;
      hwrite_reg <= 1'b0;
    end
    else if (bus_cap)
    begin
      baddr_reg  <= bus_err_addr;
      hwrite_reg <= bus_err_write;
    end
    else if (fill_cap)
      fprim_reg <= fill_primary;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      faddr_reg <= '0;
      fsyn_reg  <= '0;
    end
    else if (fill_cap)
    begin
      faddr_reg <= fill_addr;
      fsyn_reg  <= fill_syn;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      btag_reg <= '0;
    else if (bus_cap && bus_err_kind[1])
      btag_reg <= bus_err_tag;
    else if (fill_cap)
      btag_reg <= fill_tag;
  end

  // internal unit addresses keep the first error until cleared
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      daddr_reg <= '0;
      taddr_reg <= '0;
      vaddr_reg <= '0;
    end
    else
    begin
      if (dc_err_valid && dstat_q == 3'h0)
        daddr_reg <= dc_err_addr;
      if (tb_err_valid && tstat_q == 1'h0)
        taddr_reg <= tb_err_addr;
      if (ic_err_valid && vstat_q == 2'h0)
        vaddr_reg <= ic_err_addr;
    end
  end

  // hardware disable beats a software enable in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_en_reg <= `ERL_CTL_RST;
    else if (cache_err)
      ctl_en_reg <= 1'b0;
    else if (ctl_we)
      ctl_en_reg <= wr_data[`ERL_C_EN];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      iucs_en_reg <= `ERL_IUCS_RST;
    else if (ic_err_valid)
      iucs_en_reg <= 1'b0;
    else if (wr_en && hit(addr, `ERL_OFF_IUCS))
      iucs_en_reg <= wr_data[`ERL_I_EN];
  end

  assign l1d_cache_en = ctl_en_reg;
  assign l2_cache_en  = ctl_en_reg;
  assign ic_en        = iucs_en_reg;

  // machine check stays pending until the cpu takes an exception
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mchk_reg <= 1'b0;
    else if (mchk_set)
      mchk_reg <= 1'b1;
    else if (exc_take && ps_reg == PS_IDLE)
      mchk_reg <= 1'b0;
  end

  assign mchk_req = mchk_reg;
  assign hard_irq = bstat_q[`ERL_B_HARD];
  assign soft_irq = (|bstat_q[`ERL_B_FDPERR:`ERL_B_SOFT]) || (|dstat_q)
                    || tstat_q[0] || (|vstat_q);

  always_comb
  begin
    if (mchk_reg)
      notify_top = NT_MCHK;
    else if (hard_irq)
      notify_top = NT_HARD;
    else if (soft_irq)
      notify_top = NT_SOFT;
    else
      notify_top = NT_NONE;
  end

  // stack frame pusher; a take while busy is dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ps_reg         <= PS_IDLE;
      push_data      <= '0;
      psl_hold_reg   <= '0;
      frame_mchk_reg <= 1'b0;
    end
    else
    begin
      unique case (ps_reg)
        PS_IDLE:
          if (exc_take)
          begin
            ps_reg         <= PS_PC;
            push_data      <= exc_pc;
            psl_hold_reg   <= exc_psl;
            frame_mchk_reg <= mchk_reg;
          end
        PS_PC:
        begin
          ps_reg    <= PS_PSL;
          push_data <= psl_hold_reg;
        end
        PS_PSL:
          if (frame_mchk_reg)
          begin
            ps_reg    <= PS_DET0;
            push_data <= {23'h0, hwrite_reg, fprim_reg, bstat_q};
          end
          else
            ps_reg <= PS_IDLE;
        PS_DET0:
        begin
          ps_reg    <= PS_DET1;
          push_data <= faddr_reg;
        end
        PS_DET1:
          ps_reg <= PS_IDLE;
        default:
          ps_reg <= PS_IDLE;
      endcase
    end
  end

  assign push_valid = (ps_reg != PS_IDLE);

  // flush walk: one block a cycle, dirty ones go out as victims
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flush_busy <= 1'b0;
      idx_reg    <= '0;
    end
    else if (flush_busy)
    begin
      idx_reg <= idx_reg + 1'b1;
      if (idx_reg == IDXW'(NBLK - 1))
        flush_busy <= 1'b0;
    end
    else if (ctl_we && wr_data[`ERL_C_FLUSH])
    begin
      flush_busy <= 1'b1;
      idx_reg    <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_valid <= 1'b0;
      wb_idx   <= '0;
    end
    else
    begin
      wb_valid <= flush_busy && flush_dirty;
      wb_idx   <= idx_reg;
    end
  end

  assign flush_idx = idx_reg;

  always_comb
  begin
    rd_next = 32'h0;
    unique case (addr)
      `ERL_OFF_BSTAT: rd_next = {23'h0, hwrite_reg, fprim_reg, bstat_q};
      `ERL_OFF_CTL:   rd_next = {29'h0, flush_busy, 1'b0, ctl_en_reg};
      `ERL_OFF_BADDR: rd_next = baddr_reg;
      `ERL_OFF_FADDR: rd_next = faddr_reg;
      `ERL_OFF_FSYN:  rd_next = 32'(fsyn_reg);
      `ERL_OFF_BTAG:  rd_next = 32'(btag_reg);
      `ERL_OFF_DSTAT: rd_next = {29'h0, dstat_q};
      `ERL_OFF_DADDR: rd_next = daddr_reg;
      `ERL_OFF_TSTAT: rd_next = {31'h0, tstat_q};
      `ERL_OFF_TADDR: rd_next = taddr_reg;
      `ERL_OFF_IUCS:  rd_next = {29'h0, vstat_q, iucs_en_reg};
      `ERL_OFF_VADDR: rd_next = vaddr_reg;
      default:        rd_next = 32'h0;
    endcase
  end

  // reads have no side effect on any latched state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= '0;
    else if (rd_en)
      rd_data <= rd_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  second_error_a: assert property (
    bus_err_valid && bank_busy |=> bstat_q[`ERL_B_SECOND] && $stable(baddr_reg))
    else $error("second error captured or not flagged");

  auto_disable_a: assert property (
    cache_err |=> !l2_cache_en && !l1d_cache_en)
    else $error("cache not disabled after cache error");

  ctl_clear_a: assert property (
    ctl_we && !wr_data[0] |=> !l1d_cache_en && !l2_cache_en)
    else $error("control bit 0 clear left a cache on");

  primary_mchk_a: assert property (
    mchk_set |=> mchk_req ##1 (mchk_req || $past(exc_take)))
    else $error("primary fill error gave no machine check");

  later_fill_a: assert property (
    fill_err && !fill_primary && !mchk_req |=> !mchk_req)
    else $error("later quadword raised machine check");

  hard_only_a: assert property (
    bus_cap && bus_err_kind == `ERL_K_HARD && !fill_err && bstat_q == 7'h0
    && !soft_irq && !mchk_req && !dc_err_valid && !tb_err_valid && !ic_err_valid
    |=> hard_irq && !soft_irq && !mchk_req)
    else $error("hard error raised another notice");

  w1c_bus_a: assert property (
    wr_en && addr == `ERL_OFF_BSTAT && wr_data[0] && !bus_err_valid && !fill_valid
    |=> !bstat_q[0] && bstat_q[6:1] == $past(bstat_q[6:1] & ~wr_data[6:1]))
    else $error("bus status clear wrong");

  priority_a: assert property (
    (mchk_req |-> notify_top == NT_MCHK)
    and (!mchk_req && hard_irq |-> notify_top == NT_HARD))
    else $error("notification priority wrong");

  read_hold_a: assert property (
    rd_en && !wr_en && !bus_err_valid && !fill_valid
    |=> $stable(bstat_q) && $stable(baddr_reg) && $stable(faddr_reg))
    else $error("read disturbed latched state");

  frame_mchk_a: assert property (
    exc_take && ps_reg == PS_IDLE && mchk_req
    |=> push_valid [*4] ##1 !push_valid)
    else $error("machine check frame not four words");

  flush_wb_a: assert property (
    flush_busy && flush_dirty |=> wb_valid && wb_idx == $past(flush_idx))
    else $error("dirty block not written back");

  cover_seo_c: cover property (bus_err_valid && bank_busy);
  cover_mchk_frame_c: cover property (ps_reg == PS_DET1);
  cover_flush_c: cover property (flush_busy ##1 !flush_busy);
endmodule
`default_nettype wire

// File: verif/erl_tag_store.sv
`timescale 1ns/1ps
`default_nettype none
module erl_tag_store #(
  parameter int NBLK = 8,
  parameter int IDXW = 3
) (
  input  wire logic            clk,       // system clock
  input  wire logic [NBLK-1:0] dirty_map, // dirty bit per block
  input  wire logic            busy,      // flush walk running
  input  wire logic [IDXW-1:0] idx,       // block being probed
  output logic                 dirty      // probe answer
);
  logic junk_reg = 1'b0;
  // outside a walk the answer is junk, never the last value
  always_ff @(posedge clk)
    junk_reg <= ~junk_reg;
  assign dirty = busy ? dirty_map[idx] : junk_reg;
endmodule
`default_nettype wire

// File: verif/test_erl_latch.sv
`timescale 1ns/1ps
`default_nettype none
`include "erl_consts.svh"
module test_erl_latch;
  import erl_pkg::*;
  localparam int NB = 8;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam int P_FILL = 0, P_BUS = 1, P_DC = 2, P_TB = 3, P_IC = 4, P_EXC = 5;
  logic clk = 1'b0, rst_n = 1'b0, rd_q = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = '0, bus_err_addr = '0, fill_addr = '0, dc_err_addr = '0;
  logic [31:0] tb_err_addr = '0, ic_err_addr = '0, exc_pc = '0, exc_psl = '0;
  logic wr_en = 1'b0, rd_en = 1'b0, bus_err_valid = 1'b0, bus_err_write = 1'b0;
  logic fill_valid = 1'b0, fill_primary = 1'b0, fill_ecc_err = 1'b0, fill_par_err = 1'b0;
  logic dc_err_valid = 1'b0, tb_err_valid = 1'b0, ic_err_valid = 1'b0, exc_take = 1'b0;
  logic [1:0] bus_err_kind = 2'h0, ic_err_kind = 2'h0;
  logic [2:0] dc_err_kind = 3'h0;
  logic [15:0] bus_err_tag = '0, fill_tag = '0;
  logic [7:0] fill_syn = '0, dirty_map = '0;
  logic [31:0] rd_data, push_data, a, ca, s, p, q;
  logic mchk_req, hard_irq, soft_irq, l1d_cache_en, l2_cache_en, ic_en;
  logic push_valid, flush_busy, wb_valid, flush_dirty;
  erl_notify_t notify_top;
  logic [2:0] flush_idx, wb_idx;
  logic [63:0] rq[$], pq[$];
  logic [2:0] wq[$];
  int miscompares = 0;
  int n_checks = 0;
  int n;

  erl_latch #(.NBLK(NB)) u_dut (.*);
  erl_tag_store #(.NBLK(NB), .IDXW(3)) u_tags
  (
    .clk(clk), .dirty_map(dirty_map), .busy(flush_busy), .idx(flush_idx), .dirty(flush_dirty)
  );

  initial
    forever #10 clk = ~clk;

  task automatic bad(input logic [31:0] got, input logic [31:0] exp);
    miscompares++;
    $display("Error at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic cmpw(input logic [31:0] got, input logic [63:0] e);
    n_checks++;
    if ((got & e[63:32]) !== e[31:0])
      bad(got & e[63:32], e[31:0]);
  endtask
  task automatic cmpf(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp)
      bad(32'(got), 32'(exp));
  endtask
  task automatic cmpi(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp)
      bad(32'(got), 32'(exp));
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    addr <= ad;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e});
    addr <= ad;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle event pulse on the selected line, returns once the result has landed
  task automatic pulse(input int w);
    {exc_take, ic_err_valid, tb_err_valid, dc_err_valid, bus_err_valid, fill_valid} <= 6'(1 << w);
    @(posedge clk);
    {exc_take, ic_err_valid, tb_err_valid, dc_err_valid, bus_err_valid, fill_valid} <= 6'h00;
    @(posedge clk);
    #1;
  endtask
  task automatic frame(input logic mc, input logic [63:0] w3, input logic [31:0] w4);
    p = $urandom;
    q = $urandom;
    exc_pc <= p;
    exc_psl <= q;
    pq.push_back({ALL, p});
    pq.push_back({ALL, q});
    if (mc)
    begin
      pq.push_back(w3);
      pq.push_back({ALL, w4});
    end
    pulse(P_EXC);
    repeat (4) @(posedge clk);
    #1;
    cmpf(5'(pq.size()), 5'h0);
  endtask

  always @(posedge clk)
    rd_q <= rd_en;
  always @(negedge clk)
  begin
    if (rd_q)
      cmpw(rd_data, rq.pop_front());
    if (push_valid)
      cmpw(push_data, pq.pop_front());
    if (wb_valid)
      cmpi(wb_idx, wq.pop_front());
  end

  initial
  begin
    void'($urandom(52));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'h0, ALL);
    rd(8'h04, 32'h1, 32'h7);
    rd(8'h28, 32'h1, 32'h7);
    rd(8'h30, 32'h0, ALL);
    #1 cmpf({2'b0, l1d_cache_en, l2_cache_en, ic_en}, 5'h7);
    $display("test reset done");
    // non-primary fill error, then a bus error on a full bank
    a = $urandom;
    fill_addr <= a;
    fill_par_err <= 1'b1;
    pulse(P_FILL);
    cmpf({mchk_req, hard_irq, soft_irq, notify_top}, {3'b001, NT_SOFT});
    cmpf({3'b0, l1d_cache_en, l2_cache_en}, 5'h0);
    rd(8'h0c, a, ALL);
    rd(8'h00, 32'h20, 32'h7f);
    bus_err_kind <= `ERL_K_HARD;
    bus_err_addr <= ~a;
    pulse(P_BUS);
    rd(8'h00, 32'h60, 32'h7f);
    rd(8'h08, 32'h0, ALL);
    wr(8'h00, 32'h20);
    rd(8'h00, 32'h40, 32'h7f);
    wr(8'h00, 32'h40);
    rd(8'h00, 32'h0, 32'h7f);
    wr(8'h04, 32'h1);
    #1 cmpf({3'b0, l1d_cache_en, l2_cache_en}, 5'h3);
    $display("test second error done");
    ca = $urandom;
    s = $urandom;
    fill_addr <= ca;
    fill_syn <= s[7:0];
    fill_tag <= s[31:16];
    fill_primary <= 1'b1;
    fill_par_err <= 1'b0;
    fill_ecc_err <= 1'b1;
    pulse(P_FILL);
    cmpf({mchk_req, hard_irq, soft_irq, notify_top}, {3'b101, NT_MCHK});
    rd(8'h10, {24'h0, s[7:0]}, 32'hff);
    rd(8'h14, {16'h0, s[31:16]}, 32'hffff);
    frame(1'b1, {32'h7f, 32'h10}, ca);
    cmpf({mchk_req, hard_irq, soft_irq, notify_top}, {3'b001, NT_SOFT});
    wr(8'h00, 32'h10);
    wr(8'h04, 32'h1);
    $display("test machine check done");
    a = $urandom;
    bus_err_kind <= `ERL_K_HARD;
    bus_err_write <= 1'b1;
    bus_err_addr <= a;
    pulse(P_BUS);
    cmpf({mchk_req, hard_irq, soft_irq, notify_top}, {3'b010, NT_HARD});
    cmpf({3'b0, l1d_cache_en, l2_cache_en}, 5'h3);
    rd(8'h08, a, ALL);
    fill_addr <= ~a;
    pulse(P_FILL);
    cmpf({1'b0, mchk_req, hard_irq, notify_top}, {3'b011, NT_MCHK});
    rd(8'h00, 32'h41, 32'h7f);
    rd(8'h0c, ca, ALL);
    frame(1'b1, {32'h7f, 32'h41}, ca);
    wr(8'h00, 32'h7f);
    rd(8'h00, 32'h0, 32'h7f);
    #1 cmpf({mchk_req, hard_irq, soft_irq, notify_top}, {3'b000, NT_NONE});
    bus_err_write <= 1'b0;
    wr(8'h04, 32'h1);
    $display("test hard error done");
    for (int k = 1; k < 4; k++)
    begin
      a = $urandom;
      bus_err_kind <= k[1:0];
      bus_err_addr <= a;
      bus_err_tag <= a[31:16];
      pulse(P_BUS);
      rd(8'h00, 32'h1 << k, 32'h7f);
      rd(8'h08, a, ALL);
      if (k > 1)
        rd(8'h14, {16'h0, a[31:16]}, 32'hffff);
      #1 cmpf({3'b0, hard_irq, l2_cache_en}, {4'b0, k == 1});
      wr(8'h00, 32'h7f);
      wr(8'h04, 32'h1);
    end
    $display("test bus kinds done");
    for (int k = 0; k < 3; k++)
    begin
      a = $urandom;
      dc_err_kind <= 3'(1 << k);
      dc_err_addr <= a;
      pulse(P_DC);
      rd(8'h18, 32'h1 << k, 32'h7);
      rd(8'h1c, a, ALL);
      #1 cmpf({3'b0, l1d_cache_en, soft_irq}, 5'h1);
      wr(8'h18, 32'h1 << k);
      rd(8'h18, 32'h0, 32'h7);
      wr(8'h04, 32'h1);
    end
    a = $urandom;
    tb_err_addr <= a;
    pulse(P_TB);
    cmpf({mchk_req, hard_irq, soft_irq, notify_top}, {3'b001, NT_SOFT});
    rd(8'h20, 32'h1, 32'h1);
    rd(8'h24, a, ALL);
    wr(8'h20, 32'h1);
    rd(8'h20, 32'h0, 32'h1);
    frame(1'b0, 64'h0, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      a = $urandom;
      ic_err_kind <= 2'(1 << k);
      ic_err_addr <= a;
      pulse(P_IC);
      rd(8'h28, 32'h2 << k, 32'h7);
      rd(8'h2c, a, ALL);
      #1 cmpf({4'b0, ic_en}, 5'h0);
      wr(8'h28, (32'h2 << k) | 32'h1);
      rd(8'h28, 32'h1, 32'h7);
    end
    $display("test unit errors done");
    s = $urandom;
    dirty_map <= s[7:0];
    for (int i = 0; i < NB; i++)
      if (s[i])
        wq.push_back(3'(i));
    wr(8'h04, 32'h3);
    #1 cmpf({4'b0, flush_busy}, 5'h1);
    for (n = 0; n < 40 && flush_busy; n++)
      @(posedge clk);
    if (n == 40)
      bad(32'(n), 32'(NB));
    repeat (2) @(posedge clk);
    cmpf(5'(wq.size()), 5'h0);
    rd(8'h04, 32'h1, 32'h7);
    wr(8'h04, 32'h0);
    #1 cmpf({3'b0, l1d_cache_en, l2_cache_en}, 5'h0);
    wr(8'h04, 32'h1);
    $display("test flush done");
    results();
  end
endmodule
`default_nettype wire
